// file: hw/pmp_pkg.sv
package pmp_pkg;

  localparam int          CLK_PERIOD_NS  = 25;
  localparam int          LINK_PERIOD_NS = 400;
  localparam int          LINK_DIV_CYC   = LINK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  LINK_DIV_LAST  = 4'(LINK_DIV_CYC - 1);
  localparam logic [3:0]  LINK_HIGH_CYC  = 4'(LINK_DIV_CYC / 2);
  localparam int          SQE_DELAY_NS   = 1000;
  localparam int          SQE_WIDTH_NS   = 1000;
  localparam int          SQE_DELAY_CYC  = (SQE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SQE_WIDTH_CYC  = (SQE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0]  SQE_TOTAL      = 7'(SQE_DELAY_CYC + SQE_WIDTH_CYC);
  localparam logic [6:0]  SQE_WIDTH      = 7'(SQE_WIDTH_CYC);
  localparam logic [2:0]  TECH_PHONELINE = 3'h4;
  localparam logic [4:0]  MGMT_REG_CTRL  = 5'h00;
  localparam logic [4:0]  MGMT_REG_STAT  = 5'h01;
  localparam logic [4:0]  MGMT_BCAST     = 5'h00;
  localparam int          CTRL_RESET_BIT = 15;
  localparam int          CTRL_ANEG_BIT  = 12;
  localparam int          CTRL_PD_BIT    = 11;
  localparam int          CTRL_ISO_BIT   = 10;
  localparam int          STAT_ANEG_BIT  = 3;
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [3:0]  ADDR_LAST      = 4'h4;
  localparam logic [3:0]  DATA_LAST      = 4'hF;
  localparam logic [1:0]  BUF_DEPTH      = 2'h2;

  typedef enum logic [2:0] {
    MG_IDLE  = 3'b000,
    MG_START = 3'b001,
    MG_OP    = 3'b010,
    MG_PHY   = 3'b011,
    MG_REG   = 3'b100,
    MG_TA    = 3'b101,
    MG_DATA  = 3'b110
  } pmp_mgmt_st_t;

  typedef struct packed {
    logic       txEn;
    logic [3:0] txd;
    logic       mdc;
    logic       mdio;
    logic       resetPinN;
    logic       isolateRequest;
    logic       powerDownRequest;
    logic       detachDefaultStrap;
    logic       autonegAbilityStrap;
    logic [4:0] stationAddressPins;
    logic [2:0] technologyStraps;
    logic       portSelectStrap;
  } pmp_pins_t;

  typedef struct packed {
    logic       txClk;
    logic       rxClk;
    logic       crs;
    logic       col;
    logic       rxDv;
    logic       rxEr;
    logic [3:0] rxd;
  } pmp_mii_out_t;

  typedef struct packed {
    pmp_pins_t    syncA;
    pmp_pins_t    syncB;
    logic         mdcPrev;
    logic         txEnPrev;
    logic         lowPowerPrev;
    logic         rstActive;
    logic [4:0]   stationAddr;
    logic [2:0]   tech;
    logic         portSel;
    logic         anegStrap;
    logic         isoBit;
    logic         pdBit;
    logic         anegEn;
    logic         softReq;
    logic [3:0]   linkDiv;
    logic [6:0]   sqeCnt;
    logic         sfdSeen;
    logic         oeN;
    pmp_mii_out_t out;
    pmp_mgmt_st_t mg;
    logic [3:0]   bitCnt;
    logic [15:0]  sh;
    logic         opRead;
    logic         phyMatch;
    logic [4:0]   regAddr;
    logic         mdioDrive;
    logic         mdioOut;
  } pmp_state_t;
endpackage : pmp_pkg

// file: hw/pmp_two_entry_buf.sv
`timescale 1ns/10ps
module pmp_two_entry_buf import pmp_pkg::*; #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output      logic             inReady,
  output      logic             outValid,
  output      logic [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  wrPtr;
    logic                  rdPtr;
    logic [1:0]            count;
  } pmp_buf_t;

  pmp_buf_t state_reg;
  pmp_buf_t state_next;
  logic     push;
  logic     pop;

  assign inReady  = state_reg.count != BUF_DEPTH;
  assign outValid = state_reg.count != 2'h0;
  assign outData  = state_reg.mem[state_reg.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wrPtr] = inData;
      state_next.wrPtr = !state_reg.wrPtr;
    end
    if (pop) begin
      state_next.rdPtr = !state_reg.rdPtr;
    end
    state_next.count = 2'(state_reg.count + 2'(push) - 2'(pop));
    if (srst) begin
      state_next = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    state_reg <= state_next;
  end

  AST_BUF_FILLS: assert property (@(posedge clk_sys) disable iff (srst)
    push && !pop && state_reg.count == 2'h1 |=> !inReady ##0 outValid)
    else $error("buffer did not report full");
  AST_BUF_ORDER: assert property (@(posedge clk_sys) disable iff (srst)
    push && !outValid |=> outValid && outData == $past(inData))
    else $error("buffer lost first word");
  COV_BUF_FULL: cover property (@(posedge clk_sys) disable iff (srst) !inReady);
endmodule : pmp_two_entry_buf

// file: hw/pmp_mac_port.sv
`timescale 1ns/10ps
module pmp_mac_port import pmp_pkg::*; (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire pmp_pins_t    pinsIn,
  output      pmp_mii_out_t miiOut,
  output      logic         miiOeN,
  output      logic         mdioOut,
  output      logic         mdioOeN,
  output      logic [3:0]   lineTxData,
  output      logic         lineTxValid,
  input  wire logic         lineTxReady,
  output      logic         txBufReady,
  input  wire logic         lineRxActive,
  input  wire logic         lineRxSfd,
  input  wire logic         lineRxValid,
  input  wire logic [3:0]   lineRxData,
  input  wire logic         lineCollision,
  input  wire logic         txErrIn,
  output      logic         lowPowerState,
  output      logic         chipResetActive,
  output      logic         autonegEnable,
  output      logic         autonegAbility
);
  pmp_state_t state_reg;
  pmp_state_t state_next;
  logic       phoneline;
  logic       serialPort;
  logic       lowPower;
  logic       isolated;
  logic       clkRun;
  logic       tick;
  logic       capture;
  logic       serialTxBit;
  logic       serialRxBit;
  logic [3:0] capData;
  logic [3:0] divNext;
  logic       mdcRise;
  logic       mdioBit;
  logic [15:0] shiftIn;
  logic [15:0] ctrlWord;
  logic [15:0] statWord;
  logic        regKnown;

  assign phoneline   = state_reg.tech == TECH_PHONELINE;
  assign serialPort  = phoneline && !state_reg.portSel;
  assign lowPower    = state_reg.syncB.powerDownRequest || state_reg.pdBit;
  assign isolated    = state_reg.syncB.isolateRequest || state_reg.isoBit;
  // Phoneline clocks only burst while something moves
  assign clkRun      = !lowPower && (!phoneline || state_reg.syncB.txEn
                       || lineRxActive || lineTxValid);
  assign tick        = clkRun && state_reg.linkDiv == LINK_DIV_LAST;
  // A stopped divider waits on its last count, so the first rise of a burst samples
  assign divNext     = tick ? 4'h0
                     : (!clkRun ? LINK_DIV_LAST : 4'(state_reg.linkDiv + 4'h1));
  // Synced inputs lag the pins by two cycles, well inside the 400 ns period
  assign capture     = tick && state_reg.syncB.txEn;
  assign serialTxBit = state_reg.syncB.txd[0];
  assign capData     = serialPort ? {3'h0, serialTxBit} : state_reg.syncB.txd;
  assign serialRxBit = lineRxData[0];
  assign mdcRise     = state_reg.syncB.mdc && !state_reg.mdcPrev;
  assign mdioBit     = state_reg.syncB.mdio;
  assign shiftIn     = {state_reg.sh[14:0], mdioBit};
  assign ctrlWord    = (16'(state_reg.anegEn) << CTRL_ANEG_BIT)
                     | (16'(state_reg.pdBit) << CTRL_PD_BIT)
                     | (16'(state_reg.isoBit) << CTRL_ISO_BIT);
  assign statWord    = 16'(state_reg.anegStrap) << STAT_ANEG_BIT;
  assign regKnown    = state_reg.regAddr == MGMT_REG_CTRL || state_reg.regAddr == MGMT_REG_STAT;

  always_comb begin
    state_next = state_reg;
    state_next.syncA = pinsIn;
    state_next.syncB = state_reg.syncA;
    state_next.mdcPrev = state_reg.syncB.mdc;
    state_next.txEnPrev = state_reg.syncB.txEn;
    state_next.lowPowerPrev = lowPower;
    state_next.softReq = 1'b0;
    state_next.rstActive = !state_reg.syncB.resetPinN || state_reg.softReq
                           || (state_reg.lowPowerPrev && !lowPower);

    state_next.linkDiv = divNext;
    state_next.out.txClk = clkRun && divNext < LINK_HIGH_CYC;
    state_next.out.rxClk = clkRun && divNext < LINK_HIGH_CYC;
    // Set wins over the end-of-carrier clear
    state_next.sfdSeen = lineRxSfd || (state_reg.sfdSeen && lineRxActive);
    if (!lineRxActive) begin
      state_next.out.rxDv = 1'b0;
      state_next.out.rxd = 4'h0;
    end else if (tick) begin
      state_next.out.rxDv = state_reg.sfdSeen && lineRxValid;
      if (!(state_reg.sfdSeen && lineRxValid)) begin
        state_next.out.rxd = 4'h0;
      end else if (serialPort) begin
        state_next.out.rxd = {3'h0, serialRxBit};
      end else begin
        state_next.out.rxd = lineRxData;
      end
    end
    state_next.out.crs = state_reg.syncB.txEn || lineRxActive || lineTxValid;

    if (state_reg.txEnPrev && !state_reg.syncB.txEn && !phoneline) begin
      state_next.sqeCnt = SQE_TOTAL;
    end else if (state_reg.sqeCnt != 7'h00) begin
      state_next.sqeCnt = 7'(state_reg.sqeCnt - 7'h01);
    end
    state_next.out.col = lineCollision
      || (state_reg.sqeCnt != 7'h00 && state_reg.sqeCnt <= SQE_WIDTH);
    state_next.out.rxEr = 1'b0;
    state_next.oeN = isolated;

    // Management keeps running in isolation and power-down
    if (mdcRise) begin
      case (state_reg.mg)
        MG_IDLE: begin
          if (mdioBit) begin
            state_next.mg = MG_START;
            state_next.bitCnt = 4'h0;
          end
        end
        MG_START: begin
          if (state_reg.bitCnt == 4'h0) begin
            if (!mdioBit) begin
              state_next.bitCnt = 4'h1;
            end
          end else if (mdioBit) begin
            state_next.mg = MG_OP;
            state_next.bitCnt = 4'h0;
          end else begin
            state_next.mg = MG_IDLE;
          end
        end
        MG_OP: begin
          state_next.sh = shiftIn;
          state_next.bitCnt = 4'(state_reg.bitCnt + 4'h1);
          if (state_reg.bitCnt == 4'h1) begin
            state_next.bitCnt = 4'h0;
            state_next.opRead = shiftIn[1:0] == OP_READ;
            state_next.mg = (shiftIn[1:0] == OP_READ || shiftIn[1:0] == OP_WRITE)
                            ? MG_PHY : MG_IDLE;
          end
        end
        MG_PHY: begin
          state_next.sh = shiftIn;
          state_next.bitCnt = 4'(state_reg.bitCnt + 4'h1);
          if (state_reg.bitCnt == ADDR_LAST) begin
            state_next.bitCnt = 4'h0;
            state_next.phyMatch = shiftIn[4:0] == state_reg.stationAddr
                                  || shiftIn[4:0] == MGMT_BCAST;
            state_next.mg = MG_REG;
          end
        end
        MG_REG: begin
          state_next.sh = shiftIn;
          state_next.bitCnt = 4'(state_reg.bitCnt + 4'h1);
          if (state_reg.bitCnt == ADDR_LAST) begin
            state_next.bitCnt = 4'h0;
            state_next.regAddr = shiftIn[4:0];
            state_next.sh = (shiftIn[4:0] == MGMT_REG_CTRL) ? ctrlWord : statWord;
            state_next.mg = MG_TA;
          end
        end
        MG_TA: begin
          if (state_reg.bitCnt == 4'h0) begin
            state_next.bitCnt = 4'h1;
            // Unknown register or foreign address: pull-up returns ones
            state_next.mdioDrive = state_reg.opRead && state_reg.phyMatch && regKnown;
            state_next.mdioOut = 1'b0;
          end else begin
            state_next.bitCnt = 4'h0;
            state_next.mg = MG_DATA;
            state_next.mdioOut = state_reg.sh[15];
            state_next.sh = {state_reg.sh[14:0], 1'b0};
          end
        end
        MG_DATA: begin
          state_next.bitCnt = 4'(state_reg.bitCnt + 4'h1);
          if (state_reg.opRead) begin
            state_next.mdioOut = state_reg.sh[15];
            state_next.sh = {state_reg.sh[14:0], 1'b0};
          end else begin
            state_next.sh = shiftIn;
          end
          if (state_reg.bitCnt == DATA_LAST) begin
            state_next.mg = MG_IDLE;
            state_next.mdioDrive = 1'b0;
            if (!state_reg.opRead && state_reg.phyMatch
                && state_reg.regAddr == MGMT_REG_CTRL) begin
              state_next.pdBit = shiftIn[CTRL_PD_BIT];
              state_next.isoBit = shiftIn[CTRL_ISO_BIT];
              state_next.anegEn = shiftIn[CTRL_ANEG_BIT] && state_reg.anegStrap;
              state_next.softReq = shiftIn[CTRL_RESET_BIT];
            end
          end
        end
        default: begin
          state_next.mg = MG_IDLE;
        end
      endcase
    end

    // Straps are caught on the last cycles of every chip reset
    if (state_reg.rstActive) begin
      state_next.isoBit = state_reg.syncB.detachDefaultStrap;
      state_next.pdBit = 1'b0;
      state_next.anegStrap = state_reg.syncB.autonegAbilityStrap;
      state_next.anegEn = state_reg.syncB.autonegAbilityStrap;
      state_next.stationAddr = state_reg.syncB.stationAddressPins;
      state_next.tech = state_reg.syncB.technologyStraps;
      state_next.portSel = state_reg.syncB.portSelectStrap;
      state_next.softReq = 1'b0;
      state_next.linkDiv = LINK_DIV_LAST;
      state_next.sqeCnt = 7'h00;
      state_next.sfdSeen = 1'b0;
      state_next.out = '0;
      state_next.mg = MG_IDLE;
      state_next.bitCnt = 4'h0;
      state_next.mdioDrive = 1'b0;
      state_next.mdioOut = 1'b0;
    end
    if (srst) begin
      state_next = '0;
      state_next.rstActive = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    state_reg <= state_next;
  end

  // Words arriving while both entries are full are dropped; txBufReady tells
  pmp_two_entry_buf #(.WIDTH(4)) txBuf (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .inValid  (capture),
    .inData   (capData),
    .inReady  (txBufReady),
    .outValid (lineTxValid),
    .outData  (lineTxData),
    .outReady (lineTxReady)
  );

  assign miiOut          = state_reg.out;
  assign miiOeN          = state_reg.oeN;
  assign mdioOut         = state_reg.mdioOut;
  assign mdioOeN         = !state_reg.mdioDrive;
  assign lowPowerState   = lowPower;
  assign chipResetActive = state_reg.rstActive;
  assign autonegEnable   = state_reg.anegEn;
  assign autonegAbility  = state_reg.anegStrap;

  default clocking cbDef @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // Power-down or chip reset inside the period restarts the divider
  AST_TXCLK_FREE: assert property ($rose(miiOut.txClk) && !phoneline && !lowPower
    && !state_reg.rstActive ##1 (!lowPower && !state_reg.rstActive)[*8]
    ##1 (!lowPower && !state_reg.rstActive)[*7] |=> $rose(miiOut.txClk))
    else $error("transmit clock not free running at 16 cycles");
  AST_TX_CAPTURE: assert property ($rose(miiOut.txClk) && $past(state_reg.syncB.txEn)
    && $past(txBufReady) && !$past(lineTxReady) |-> lineTxValid)
    else $error("enabled nibble not captured");
  AST_TX_DISCARD: assert property ($rose(miiOut.txClk) && !$past(state_reg.syncB.txEn)
    && !$past(lineTxValid) |-> !lineTxValid)
    else $error("nibble captured without enable");
  AST_SERIAL_TX: assert property (lineTxValid && serialPort |-> lineTxData[3:1] == 3'h0)
    else $error("serial transmit used upper data lines");
  AST_SERIAL_RX: assert property (serialPort |-> miiOut.rxd[3:1] == 3'h0)
    else $error("serial receive used upper data lines");
  AST_CRS: assert property (lineRxActive && !state_reg.rstActive |=> miiOut.crs)
    else $error("carrier sense missing during receive");
  AST_COL: assert property (lineCollision && !state_reg.rstActive |=> miiOut.col)
    else $error("collision not reported");
  AST_SQE: assert property ($fell(state_reg.syncB.txEn) && !phoneline && !state_reg.rstActive
    |-> ##[40:44] miiOut.col)
    else $error("heartbeat pulse missing");
  AST_RXDV: assert property ($rose(miiOut.rxDv) |-> $past(state_reg.sfdSeen))
    else $error("receive valid without frame start");
  AST_ISOLATE: assert property (state_reg.syncB.isolateRequest |=> miiOeN)
    else $error("isolate pin did not float outputs");
  AST_MDIO_DRIVE: assert property (!mdioOeN |-> state_reg.opRead && state_reg.phyMatch
    && (state_reg.mg == MG_TA || state_reg.mg == MG_DATA))
    else $error("management line driven outside read data");
  AST_ISO_DEFAULT: assert property (state_reg.rstActive |=>
    state_reg.isoBit == $past(state_reg.syncB.detachDefaultStrap))
    else $error("isolate bit not loaded from strap");
  AST_RESET_PIN: assert property (!state_reg.syncB.resetPinN |=> state_reg.rstActive)
    else $error("reset pin ignored");
  AST_PD_EXIT: assert property ($fell(lowPower) |=> state_reg.rstActive)
    else $error("no reset on leaving power-down");
  AST_RXER: assert property (!miiOut.rxEr)
    else $error("receive error output raised");

  COV_SQE: cover property ($fell(state_reg.syncB.txEn) && !phoneline ##[40:44] miiOut.col);
  COV_RXDV: cover property ($rose(miiOut.rxDv));
  COV_READ: cover property ($fell(mdioOeN));
endmodule : pmp_mac_port

// file: verification/pmp_mac_model.sv
`timescale 1ns/10ps
module pmp_mac_model import pmp_pkg::*; (
  input  wire logic       clk_sys,
  input  wire logic       txClk,
  output      logic       txEn,
  output      logic [3:0] txd
);
  initial begin
    txEn = 1'b0;
    txd  = 4'h0;
  end
  // Nibbles change just after a transmit clock rise, far from the next sample
  task automatic sendNibbles(input logic [3:0] first, input int count);
    for (int i = 0; i < count; i++) begin
      @(posedge txClk);
      @(negedge clk_sys);
      txEn = 1'b1;
      txd  = first + 4'(i);
    end
    @(posedge txClk);
    @(negedge clk_sys);
    txEn = 1'b0;
    txd  = ~txd; // Stale lines must not be taken
  endtask : sendNibbles
endmodule : pmp_mac_model

// file: verification/tb.sv
`timescale 1ns/10ps
module tb import pmp_pkg::*;;
  logic         clk_sys, srst, mBit, mdioWire, macTxEn, rstSeen;
  logic [3:0]   macTxd, lineTxData, lineRxData;
  pmp_pins_t    pins, pinsDrv;
  pmp_mii_out_t miiOut;
  logic         miiOeN, mdioOut, mdioOeN, lineTxValid, lineTxReady, txBufReady;
  logic         lineRxActive, lineRxSfd, lineRxValid, lineCollision, txErrIn;
  logic         lowPowerState, chipResetActive, autonegEnable, autonegAbility;
  int           error_cnt, checks_done, txRises;
  pmp_mac_port i_dut (.clk_sys(clk_sys), .srst(srst), .pinsIn(pinsDrv), .miiOut(miiOut),
    .miiOeN(miiOeN), .mdioOut(mdioOut), .mdioOeN(mdioOeN), .lineTxData(lineTxData),
    .lineTxValid(lineTxValid), .lineTxReady(lineTxReady), .txBufReady(txBufReady),
    .lineRxActive(lineRxActive), .lineRxSfd(lineRxSfd), .lineRxValid(lineRxValid),
    .lineRxData(lineRxData), .lineCollision(lineCollision), .txErrIn(txErrIn),
    .lowPowerState(lowPowerState), .chipResetActive(chipResetActive),
    .autonegEnable(autonegEnable), .autonegAbility(autonegAbility));
  pmp_mac_model i_mac (.clk_sys(clk_sys), .txClk(miiOut.txClk), .txEn(macTxEn), .txd(macTxd));
  // Pull-up on the shared data line, either side pulls low
  assign mdioWire = mBit & (mdioOeN | mdioOut);
  always_comb begin
    pinsDrv      = pins;
    pinsDrv.mdio = mdioWire;
    pinsDrv.txEn = macTxEn;
    pinsDrv.txd  = macTxd;
  end
  always @(posedge miiOut.txClk) txRises++;
  always @(posedge clk_sys) if (chipResetActive === 1'b1) rstSeen = 1'b1;
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic doReset();
    srst = 1'b1;
    cyc(20);
    srst = 1'b0;
    for (int i = 0; i < 50 && chipResetActive !== 1'b0; i++) cyc(1);
  endtask : doReset
  // One management clock period of 200 ns, sampled just before the rise
  task automatic mgmt(input logic [4:0] phy, input logic [4:0] regA, input logic [1:0] op,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [32:0] f;
    f = {3'h5, op, phy, regA, (op == OP_READ) ? 2'h3 : 2'h2, wd};
    for (int i = 32; i >= 0; i--) begin
      mBit = f[i];
      pins.mdc = 1'b0;
      cyc(4);
      rd = {rd[14:0], mdioWire};
      pins.mdc = 1'b1;
      cyc(4);
    end
    mBit = 1'b1;
    cyc(6);
  endtask : mgmt
  task automatic rdReg(input string what, input logic [4:0] phy, input logic [4:0] regA,
                       input logic [15:0] exp);
    logic [15:0] rd;
    mgmt(phy, regA, OP_READ, 16'hFFFF, rd);
    cmp(what, exp, rd);
  endtask : rdReg
  task automatic wrReg(input logic [15:0] wd);
    logic [15:0] rd;
    mgmt(5'h13, MGMT_REG_CTRL, OP_WRITE, wd, rd);
  endtask : wrReg
  task automatic popTx(input logic [3:0] exp);
    cmp("tx valid", 16'h1, lineTxValid);
    cmp("tx data", {12'h000, exp}, {12'h000, lineTxData});
    lineTxReady = 1'b1;
    cyc(1);
    lineTxReady = 1'b0;
  endtask : popTx
  task automatic rxFrame(input logic [3:0] nib, input logic [3:0] exp);
    lineRxActive = 1'b1;
    lineRxSfd = 1'b1;
    cyc(1);
    lineRxSfd = 1'b0;
    lineRxValid = 1'b1;
    lineRxData = nib;
    @(posedge miiOut.rxClk);
    @(posedge miiOut.rxClk);
    cyc(1);
    cmp("rx valid", 16'h1, miiOut.rxDv);
    cmp("rx data", {12'h000, exp}, {12'h000, miiOut.rxd});
    cmp("crs rx", 16'h1, miiOut.crs);
    cmp("rx error", 16'h0, miiOut.rxEr);
    lineRxActive = 1'b0;
    lineRxValid = 1'b0;
    cyc(3);
    cmp("rx idle", 16'h0, miiOut.rxDv);
  endtask : rxFrame
  initial begin
    #400us;
    error_cnt++;
    results();
  end
  initial begin
    {srst, lineTxReady, lineRxActive, lineRxSfd, lineRxValid, lineCollision} = '0;
    {error_cnt, checks_done, txRises} = '0;
    {lineRxData, rstSeen, mBit, txErrIn} = {4'h0, 3'h3};
    pins = '0;
    pins.resetPinN = 1'b1;
    pins.autonegAbilityStrap = 1'b1;
    pins.stationAddressPins = 5'h13;
    pins.portSelectStrap = 1'b1;
    cyc(1);
    doReset();
    cmp("iso after reset", 16'h0, miiOeN);
    cmp("aneg ability", 16'h1, autonegAbility);
    cmp("aneg enable", 16'h1, autonegEnable);
    rdReg("ctrl bcast", MGMT_BCAST, MGMT_REG_CTRL, 16'h1000);
    rdReg("stat own", 5'h13, MGMT_REG_STAT, 16'h0008);
    rdReg("stat other", 5'h05, MGMT_REG_STAT, 16'hFFFF);
    txRises = 0;
    cyc(160);
    cmp("tp clock", 16'(10), 16'(txRises));
    $display("test mgmt and clocks done");
    i_mac.sendNibbles(4'h5, 3);
    cmp("buf full", 16'h0, txBufReady);
    cmp("crs tx", 16'h1, miiOut.crs);
    popTx(4'h5);
    popTx(4'h6);
    cyc(14);
    cmp("sqe early", 16'h0, miiOut.col);
    cyc(40);
    cmp("sqe pulse", 16'h1, miiOut.col);
    cmp("tx drained", 16'h0, lineTxValid);
    cyc(32);
    cmp("sqe end", 16'h0, miiOut.col);
    lineCollision = 1'b1;
    cyc(3);
    cmp("collision", 16'h1, miiOut.col);
    lineCollision = 1'b0;
    rxFrame(4'hB, 4'hB);
    $display("test data path done");
    pins.isolateRequest = 1'b1;
    cyc(4);
    cmp("iso pin", 16'h1, miiOeN);
    rdReg("stat isolated", 5'h13, MGMT_REG_STAT, 16'h0008);
    pins.isolateRequest = 1'b0;
    wrReg(16'h1400);
    cmp("iso bit", 16'h1, miiOeN);
    pins.detachDefaultStrap = 1'b1;
    rstSeen = 1'b0;
    wrReg(16'h9000);
    cmp("soft reset", 16'h1, rstSeen);
    cmp("iso strap one", 16'h1, miiOeN);
    pins.detachDefaultStrap = 1'b0;
    pins.resetPinN = 1'b0;
    cyc(5);
    cmp("reset pin", 16'h1, chipResetActive);
    pins.resetPinN = 1'b1;
    cyc(8);
    cmp("iso strap zero", 16'h0, miiOeN);
    wrReg(16'h1800);
    cmp("pd bit", 16'h1, lowPowerState);
    txRises = 0;
    rdReg("stat pd", 5'h13, MGMT_REG_STAT, 16'h0008);
    cmp("pd clocks", 16'h0, 16'(txRises));
    rstSeen = 1'b0;
    wrReg(16'h1000);
    cmp("pd exit reset", 16'h1, rstSeen);
    pins.powerDownRequest = 1'b1;
    cyc(4);
    cmp("pd pin", 16'h1, lowPowerState);
    pins.powerDownRequest = 1'b0;
    $display("test control done");
    pins.technologyStraps = TECH_PHONELINE;
    pins.portSelectStrap = 1'b0;
    doReset();
    txRises = 0;
    cyc(40);
    cmp("phone idle clock", 16'h0, 16'(txRises));
    rxFrame(4'hB, 4'h1);
    $display("test serial port done");
    results();
  end
endmodule : tb
